/* File: hdl/cstot_ctrl.sv */
// Convert-start sequencing and over-temperature indicator, with serial-read clear on link clock
`timescale 1ns/1ps
`default_nettype none
module cstot_ctrl #(
	parameter int POWERUP_CYCLES = cstot_pkg::CSTOT_POWERUP_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic convert_start_pin_in,
	input wire logic conv_done_in,
	input wire cstot_pkg::cstot_result_type result_in,
	input wire logic [cstot_pkg::CSTOT_LIMIT_W-1:0] over_temp_limit_register_in,
	input wire logic link_clk_in,
	input wire logic link_srst_in,
	input wire logic serial_read_done_in,
	output logic powered_up_out,
	output logic hold_out,
	output logic conv_start_out,
	output logic over_temp_indicator_out
);
	import cstot_pkg::*;

	logic cs_meta_q;
	logic cs_meta_d;
	logic cs_sync_q;
	logic cs_sync_d;
	logic cs_prev_q;
	logic cs_prev_d;
	logic cs_rise;
	logic cs_fall;
	cstot_state_type state_q;
	cstot_state_type state_d;
	logic [CSTOT_CNT_W-1:0] cnt_q;
	logic [CSTOT_CNT_W-1:0] cnt_d;
	logic powered_q;
	logic powered_d;
	logic hold_q;
	logic hold_d;
	logic start_q;
	logic start_d;
	logic oti_q;
	logic oti_d;
	logic rd_tgl_q;
	logic rd_tgl_d;
	logic rd_meta_q;
	logic rd_meta_d;
	logic rd_sync_q;
	logic rd_sync_d;
	logic rd_prev_q;
	logic rd_prev_d;
	logic rd_clear;
	logic over_limit;

	// Link domain: read completion becomes a toggle
	always_comb begin
		rd_tgl_d = rd_tgl_q ^ serial_read_done_in;
	end

	always_ff @(posedge link_clk_in) begin
		if (link_srst_in) begin
			rd_tgl_q <= 1'b0;
		end else begin
			rd_tgl_q <= rd_tgl_d;
		end
	end

	// Start pin synchroniser; only the second stage feeds the edge detector
	always_comb begin
		cs_meta_d = convert_start_pin_in;
		cs_sync_d = cs_meta_q;
		cs_prev_d = cs_sync_q;
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			cs_meta_q <= 1'b0;
			cs_sync_q <= 1'b0;
			cs_prev_q <= 1'b0;
		end else begin
			cs_meta_q <= cs_meta_d;
			cs_sync_q <= cs_sync_d;
			cs_prev_q <= cs_prev_d;
		end
	end

	// Read toggle synchroniser into the main clock
	always_comb begin
		rd_meta_d = rd_tgl_q;
		rd_sync_d = rd_meta_q;
		rd_prev_d = rd_sync_q;
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rd_meta_q <= 1'b0;
			rd_sync_q <= 1'b0;
			rd_prev_q <= 1'b0;
		end else begin
			rd_meta_q <= rd_meta_d;
			rd_sync_q <= rd_sync_d;
			rd_prev_q <= rd_prev_d;
		end
	end

	// Edge detect reset low matches the idle pin, so no false rise after reset
	always_comb begin
		cs_rise = cs_sync_q & ~cs_prev_q;
		cs_fall = ~cs_sync_q & cs_prev_q;
		rd_clear = rd_sync_q ^ rd_prev_q;
		// Only the upper bits of the code meet the narrower limit
		over_limit = result_in.valid && (result_in.channel == CSTOT_CHAN_TEMP)
			&& (result_in.code[CSTOT_RESULT_W-1 -: CSTOT_LIMIT_W] > over_temp_limit_register_in);
	end

	always_comb begin
		state_d = state_q;
		powered_d = powered_q;
		hold_d = hold_q;
		start_d = 1'b0;
		case (state_q)
			CSTOT_IDLE: begin
				if (cs_rise) begin
					state_d = CSTOT_POWERUP;
					powered_d = 1'b1;
				end
			end
			CSTOT_POWERUP: begin
				// Pin already low when the timer expires: enter hold at once
				if (cnt_q != '0) begin
					state_d = CSTOT_POWERUP;
				end else if (!cs_sync_q) begin
					state_d = CSTOT_CONVERT;
					hold_d = 1'b1;
					start_d = 1'b1;
				end else begin
					state_d = CSTOT_WAIT_FALL;
				end
			end
			CSTOT_WAIT_FALL: begin
				if (cs_fall) begin
					state_d = CSTOT_CONVERT;
					hold_d = 1'b1;
					start_d = 1'b1;
				end
			end
			CSTOT_CONVERT: begin
				if (conv_done_in) begin
					state_d = CSTOT_IDLE;
					hold_d = 1'b0;
					powered_d = 1'b0;
				end
			end
			default: begin
				state_d = CSTOT_IDLE;
				hold_d = 1'b0;
				powered_d = 1'b0;
			end
		endcase
	end

	// Set wins over a simultaneous read clear
	always_comb begin
		oti_d = oti_q;
		if (rd_clear) begin
			oti_d = 1'b0;
		end
		if (over_limit) begin
			oti_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			oti_q <= 1'b0;
		end else begin
			oti_q <= oti_d;
		end
	end

	// Power-up timer: loaded on a detected rise, runs down to zero while powering
	always_comb begin
		cnt_d = cnt_q;
		if ((state_q == CSTOT_IDLE) && cs_rise) begin
			cnt_d = CSTOT_CNT_W'(POWERUP_CYCLES - 1);
		end else if ((state_q == CSTOT_POWERUP) && (cnt_q != '0)) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Sequencer state and its registered outputs
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			state_q <= CSTOT_IDLE;
			powered_q <= 1'b0;
			hold_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			state_q <= state_d;
			powered_q <= powered_d;
			hold_q <= hold_d;
			start_q <= start_d;
		end
	end

	// Every output is a register, no logic after the flops

	assign powered_up_out = powered_q;
	assign hold_out = hold_q;
	assign conv_start_out = start_q;
	assign over_temp_indicator_out = oti_q;
endmodule
`default_nettype wire

/* File: inc/cstot_pkg.sv */
// Constants and carrier types for the convert-start and over-temperature control block
package cstot_pkg;
	localparam int CSTOT_CLK_MHZ = 25;
	localparam int CSTOT_POWERUP_US = 4;
	localparam int CSTOT_POWERUP_CYCLES = CSTOT_POWERUP_US * CSTOT_CLK_MHZ;
	localparam int CSTOT_CNT_W = 8;
	localparam int CSTOT_RESULT_W = 10;
	localparam int CSTOT_LIMIT_W = 8;
	localparam int CSTOT_CHAN_W = 3;
	localparam logic [CSTOT_CHAN_W-1:0] CSTOT_CHAN_TEMP = 3'h0;
	localparam logic [CSTOT_CHAN_W-1:0] CSTOT_CHAN_EXT = 3'h4;

	typedef struct packed {
		logic valid;
		logic [CSTOT_CHAN_W-1:0] channel;
		logic [CSTOT_RESULT_W-1:0] code;
	} cstot_result_type;

	typedef enum logic [3:0] {
		CSTOT_IDLE = 4'h1,
		CSTOT_POWERUP = 4'h2,
		CSTOT_WAIT_FALL = 4'h4,
		CSTOT_CONVERT = 4'h8
	} cstot_state_type;
endpackage

/* File: verification/cstot_partner.sv */
// Converter model: answers a start with done and a result
`timescale 1ns/1ps
`default_nettype none
module cstot_partner
	import cstot_pkg::*;
(
	input wire logic clk_in,
	input wire logic start_in,
	input wire logic [12:0] req_in,
	output var cstot_result_type res_out,
	output logic done_out
);
	int n = 0;
	initial {done_out, res_out} = '0;
	always @(posedge clk_in) begin
		n <= start_in ? 8 : n - (n > 0);
		done_out <= n == 1;
		res_out <= n == 1 ? {1'b1, req_in} : {1'b0, ~req_in};
	end
endmodule
`default_nettype wire

/* File: verification/cstot_asserts.sv */
// Checker for the convert-start control block
`timescale 1ns/1ps
`default_nettype none
module cstot_asserts
	import cstot_pkg::*;
#(parameter int POWERUP_CYCLES = 5) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic convert_start_pin_in,
	input wire logic conv_done_in,
	input wire cstot_result_type result_in,
	input wire logic [7:0] over_temp_limit_register_in,
	input wire logic powered_up_out,
	input wire logic hold_out,
	input wire logic conv_start_out,
	input wire logic over_temp_indicator_out
);
	int up = 0;
	always_ff @(posedge ref_clk_in) up <= powered_up_out && !srst_in ? up + 1 : 0;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	sequence s_fire; conv_start_out && hold_out ##1 !conv_start_out; endsequence
	a_rise_pwr: assert property ($rose(convert_start_pin_in) |-> ##[2:5] powered_up_out) else $error("pwr");
	a_hold_wait: assert property (conv_start_out |-> up >= POWERUP_CYCLES - 1) else $error("early");
	a_long_fall: assert property ($fell(convert_start_pin_in) && up > POWERUP_CYCLES + 1 && !hold_out
		|-> ##[1:6] s_fire) else $error("late");
	a_done_track: assert property (conv_done_in && hold_out |=> !hold_out) else $error("track");
	a_start_pulse: assert property (conv_start_out |-> s_fire) else $error("start pulse");
	a_oti_set: assert property (result_in.valid && !result_in.channel && result_in.code[9:2] >
		over_temp_limit_register_in |=> over_temp_indicator_out) else $error("oti");
endmodule
bind cstot_ctrl cstot_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_chk (
	.ref_clk_in(ref_clk_in),
	.srst_in(srst_in),
	.convert_start_pin_in(convert_start_pin_in),
	.conv_done_in(conv_done_in),
	.result_in(result_in),
	.over_temp_limit_register_in(over_temp_limit_register_in),
	.powered_up_out(powered_up_out),
	.hold_out(hold_out),
	.conv_start_out(conv_start_out),
	.over_temp_indicator_out(over_temp_indicator_out)
);
`default_nettype wire

/* File: verification/testbench.sv */
// Testbench for the convert-start control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cstot_pkg::*;
	logic ref_clk_in = 0, srst_in = 1, link_srst_in = 1, convert_start_pin_in = 0, link_clk_in = 0;
	logic serial_read_done_in = 0, conv_done_in, powered_up_out, hold_out, conv_start_out, over_temp_indicator_out;
	logic [7:0] over_temp_limit_register_in = 8'h40;
	logic [12:0] req = 0;
	cstot_result_type result_in;
	localparam int PU = 5;
	int err_total = 0, n_checks = 0;
	always #20 ref_clk_in = ~ref_clk_in;
	always #3 link_clk_in = ~link_clk_in;
	cstot_partner i_cnv (.clk_in(ref_clk_in), .start_in(conv_start_out), .req_in(req), .res_out(result_in),
		.done_out(conv_done_in));
	cstot_ctrl #(.POWERUP_CYCLES(PU)) i_dut (
		.ref_clk_in(ref_clk_in),
		.srst_in(srst_in),
		.convert_start_pin_in(convert_start_pin_in),
		.conv_done_in(conv_done_in),
		.result_in(result_in),
		.over_temp_limit_register_in(over_temp_limit_register_in),
		.link_clk_in(link_clk_in),
		.link_srst_in(link_srst_in),
		.serial_read_done_in(serial_read_done_in),
		.powered_up_out(powered_up_out),
		.hold_out(hold_out),
		.conv_start_out(conv_start_out),
		.over_temp_indicator_out(over_temp_indicator_out)
	);
	task automatic timeout();
		err_total++;
		$display("[ERR] wait_limit exp 0 got 1");
		close_out();
	endtask
	task automatic chk(string s, int e, logic g);
		n_checks++;
		if (g !== e[0]) begin
			err_total++;
			$display("[ERR] %s exp %0d got %b", s, e, g);
		end
	endtask
	// Pin rises at edge 0 and falls at edge hi; outputs are sampled at falling edges
	task automatic t_pulse(int hi);
		int k;
		int exp_edge;
		exp_edge = ((hi > PU) ? hi : PU) + 3;
		convert_start_pin_in <= 1'b1;
		for (k = 0; k < 300; k++) begin
			@(negedge ref_clk_in);
			if (k == 3) chk("powered", 1, powered_up_out);
			if (hold_out === 1'b1) break;
			@(posedge ref_clk_in);
			if (k + 1 == hi) convert_start_pin_in <= 1'b0;
		end
		if (k == 300) timeout();
		chk("hold_edge", 1, k == exp_edge);
		chk("start", 1, conv_start_out);
		@(posedge ref_clk_in);
		convert_start_pin_in <= 1'b0;
		@(negedge ref_clk_in);
		chk("start_len", 0, conv_start_out);
		chk("held", 1, hold_out);
		for (k = 0; k < 40 && hold_out !== 1'b0; k++) @(negedge ref_clk_in);
		if (k == 40) timeout();
		chk("track", 0, hold_out);
		chk("powered_dn", 0, powered_up_out);
		@(posedge ref_clk_in);
		$display("pulse %0d done", hi);
	endtask
	task automatic t_oti(logic [12:0] r, int e);
		req <= r;
		t_pulse(2);
		chk("oti", e, over_temp_indicator_out);
		@(posedge link_clk_in) serial_read_done_in <= 1;
		@(posedge link_clk_in) serial_read_done_in <= 0;
		repeat (6) @(posedge ref_clk_in);
		chk("clear", 0, over_temp_indicator_out);
		$display("oti %h done", r);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk_in);
		srst_in <= 0;
		link_srst_in <= 0;
		@(posedge ref_clk_in);
		t_pulse(2);
		t_pulse(6);
		t_pulse(20);
		t_oti(13'h0104, 1);
		t_oti(13'h0100, 0);
		t_oti(13'h13ff, 0);
		close_out();
	end
endmodule
`default_nettype wire
